// *** src/reset_pin_pkg.sv ***
// constants for the reset pin state control block
package reset_pin_pkg;
   // mode select bit positions on the data bus
   localparam int unsigned BOOT_WIDTH_BIT = 0;
   localparam int unsigned CS_LOW_BIT     = 1;
   localparam int unsigned CS_MID_BIT     = 2;
   localparam int unsigned CS_HIGH_LSB    = 3;
   localparam int unsigned CS_HIGH_COUNT  = 5;
   localparam int unsigned PORTE_BIT      = 8;
   localparam int unsigned PORTF_BIT      = 9;
   localparam int unsigned DATA_WIDTH     = 16;
   // latched mode with all data lines pulled high (not used, mode_q keeps its value through reset), and reset values of the port direction and alternate registers
   localparam logic [15:0] MODE_RESET      = 16'hFFFF;
   localparam logic [7:0]  PORT_DIR_RESET  = 8'h00;
   localparam logic [7:0]  PORT_ALT_RESET  = 8'h00;
   // cycles from release to the first bus cycle, in output clock cycles
   localparam int unsigned FIRST_BUS_CYCLES = 10;
   localparam int unsigned CLK_PER_OUTCLK   = 1;
   localparam int unsigned START_DELAY      = FIRST_BUS_CYCLES * CLK_PER_OUTCLK;
   localparam logic [3:0]  START_COUNT      = 4'(START_DELAY);
endpackage

// *** src/pin_sync.sv ***
// three-stage synchroniser for a pin bundle
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned W = 1
) (
   // clock
   input  wire logic         clk,
   // pins
   input  wire logic [W-1:0] pinIn,
   // synchronised level, changes when stages two and three agree
   output logic      [W-1:0] pinOut
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clk) begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   always_ff @(posedge clk) begin
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            pinOut[i] <= s2_q[i];
         end
      end
   end
endmodule // pin_sync

// *** src/reset_pin_state_control.sv ***
// pin role and drive state through system reset
`timescale 1ns/1ps
module reset_pin_state_control (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // mode select pins sampled during reset
   input  wire logic [15:0] dataPinIn,
   input  wire logic        clockSourceSelectPin,
   // functional values from the rest of the chip
   input  wire logic [10:0] chipSelectFn,
   input  wire logic        bootSelectFn,
   input  wire logic        strobeOutFn,
   input  wire logic [7:0]  portDirWr,
   input  wire logic        portDirWe,
   input  wire logic [7:0]  portAltWr,
   input  wire logic        portAltWe,
   // integration module pins
   output logic [10:0] chipSelectN,
   output logic        bootChipSelectN,
   output logic        busPinOe,
   output logic        strobeOut,
   output logic        strobeOe,
   // latched mode
   output logic        bootWide,
   output logic [10:0] csAsAddress,
   output logic        portEMode,
   output logic        portFMode,
   output logic        clockSourceSelect,
   output logic        modeValid,
   output logic        exceptionStart,
   // module port pins
   output logic [7:0]  portOe,
   output logic [7:0]  portAlt
);
   typedef enum logic [1:0] {IN_RESET, LATCH, WAIT_START, RUN} phase_e;

   phase_e      phase_q;
   logic [15:0] dataSync;
   logic        clkSelSync;
   logic [15:0] mode_q;
   logic        clkSel_q;
   logic [3:0]  count_q;
   logic [7:0]  portDir_q;
   logic [7:0]  portAlt_q;
   logic        released;

   // data pins arrive from outside the clock domain
   pin_sync #(.W(17)) u_sync (
      .clk    (clk),
      .pinIn  ({clockSourceSelectPin, dataPinIn}),
      .pinOut ({clkSelSync, dataSync})
   );

   // reset phase: latch the mode first, then start exception processing
   always_ff @(posedge clk) begin
      if (reset) begin
         phase_q <= IN_RESET;
      end else begin
         unique case (phase_q)
            IN_RESET:   phase_q <= LATCH;
            LATCH:      phase_q <= WAIT_START;
            WAIT_START: if (count_q == 4'h0) phase_q <= RUN;
            RUN:        phase_q <= RUN;
         endcase
      end
   end

   // first bus cycle waits so mode drivers can let go of the data bus
   always_ff @(posedge clk) begin
      if (reset || phase_q != WAIT_START) begin
         count_q <= reset_pin_pkg::START_COUNT - 4'h1;
      end else if (count_q != 4'h0) begin
         count_q <= count_q - 4'h1;
      end
   end

   // sampled once at the release edge and held through reset until the next release
   always_ff @(posedge clk) begin
      if (reset) begin
         mode_q   <= mode_q;
         clkSel_q <= clkSel_q;
      end else if (phase_q == IN_RESET) begin
         mode_q   <= dataSync;
         clkSel_q <= clkSelSync;
      end
   end

   // port direction and alternate function cleared by reset
   always_ff @(posedge clk) begin
      if (reset) begin
         portDir_q <= reset_pin_pkg::PORT_DIR_RESET;
      end else if (portDirWe && phase_q == RUN) begin
         portDir_q <= portDirWr;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         portAlt_q <= reset_pin_pkg::PORT_ALT_RESET;
      end else if (portAltWe && phase_q == RUN) begin
         portAlt_q <= portAltWr;
      end
   end

   assign released = (phase_q == WAIT_START) || (phase_q == RUN);

   // role decode: high chip selects turn to address from line 6 upward
   function automatic logic [10:0] addrDecode(input logic [15:0] m);
      logic [10:0] r;
      r = 11'h000;
      for (int i = 0; i < reset_pin_pkg::CS_HIGH_COUNT; i++) begin
         for (int j = 0; j <= i; j++) begin
            if (!m[reset_pin_pkg::CS_HIGH_LSB + i]) r[6 + j] = 1'b1;
         end
      end
      for (int k = 0; k < 3; k++) begin
         if (!m[reset_pin_pkg::CS_LOW_BIT]) r[k] = 1'b1;
         if (!m[reset_pin_pkg::CS_MID_BIT]) r[3 + k] = 1'b1;
      end
      return r;
   endfunction

   always_ff @(posedge clk) begin
      if (reset) begin
         bootWide          <= 1'b1;
         csAsAddress       <= 11'h000;
         portEMode         <= 1'b0;
         portFMode         <= 1'b0;
         clockSourceSelect <= 1'b1;
         modeValid         <= 1'b0;
      end else begin
         bootWide          <= mode_q[reset_pin_pkg::BOOT_WIDTH_BIT];
         csAsAddress       <= addrDecode(mode_q);
         portEMode         <= !mode_q[reset_pin_pkg::PORTE_BIT];
         portFMode         <= !mode_q[reset_pin_pkg::PORTF_BIT];
         clockSourceSelect <= clkSel_q;
         modeValid         <= released;
      end
   end

   // exception processing starts one cycle after the latch
   always_ff @(posedge clk) begin
      if (reset) begin
         exceptionStart <= 1'b0;
      end else begin
         exceptionStart <= (phase_q == LATCH);
      end
   end

   // pin drive: selects high in reset, boot select driven from bootSelectFn after release
   always_ff @(posedge clk) begin
      if (reset || !released) begin
         chipSelectN     <= 11'h7FF;
         bootChipSelectN <= 1'b1;
         busPinOe        <= 1'b0;
         strobeOe        <= 1'b0;
         strobeOut       <= 1'b1;
      end else begin
         chipSelectN     <= ~chipSelectFn | csAsAddress;
         bootChipSelectN <= ~bootSelectFn;
         busPinOe        <= (phase_q == RUN);
         strobeOe        <= !portEMode;
         strobeOut       <= strobeOutFn;
      end
   end

   // ports float unless software later sets a direction
   always_ff @(posedge clk) begin
      if (reset || !released) begin
         portOe  <= 8'h00;
         portAlt <= 8'h00;
      end else begin
         portOe  <= portDir_q;
         portAlt <= portAlt_q;
      end
   end

   a_cs_high_reset: assert property (@(posedge clk)
      reset |=> chipSelectN == 11'h7FF && bootChipSelectN)
      else $error("chip selects not high in reset");

   a_bus_float_reset: assert property (@(posedge clk)
      reset |=> !busPinOe && !strobeOe)
      else $error("bus pins driven in reset");

   a_port_input_reset: assert property (@(posedge clk)
      reset |=> portOe == 8'h00 && portAlt == 8'h00)
      else $error("ports not inputs in reset");

   a_dir_cleared: assert property (@(posedge clk)
      reset |=> portDir_q == 8'h00 && portAlt_q == 8'h00)
      else $error("direction not cleared");

   a_boot_low_after: assert property (@(posedge clk) disable iff (reset)
      $fell(reset) ##0 !reset[*3] |-> ##1 bootChipSelectN == !bootSelectFn)
      else $error("boot select wrong after release");

   a_latch_then_start: assert property (@(posedge clk) disable iff (reset)
      phase_q == LATCH |=> exceptionStart ##1 !exceptionStart)
      else $error("exception start out of order");

   a_mode_held: assert property (@(posedge clk) disable iff (reset)
      phase_q == RUN |=> $stable(mode_q) && $stable(csAsAddress) && $stable(bootWide))
      else $error("mode changed after latch");

   a_ports_float_after: assert property (@(posedge clk) disable iff (reset)
      phase_q == LATCH |=> portOe == 8'h00)
      else $error("ports not floating after release");

   a_portf_decode: assert property (@(posedge clk) disable iff (reset)
      phase_q == RUN |-> portFMode == !mode_q[reset_pin_pkg::PORTF_BIT])
      else $error("port f role mismatch");
endmodule // reset_pin_state_control

// *** tb/mode_select_driver.sv ***
// far-side model: mode-select conditioning on the data bus
`timescale 1ns/1ps
module mode_select_driver (
   // board reset
   input  wire logic        reset,
   // lines held low while reset is held
   input  wire logic [15:0] holdLow,
   input  wire logic        clockLow,
   // bus side
   output logic      [15:0] dataPin,
   output logic             clockPin
);
   // released lines read high through the weak pull-ups
   // letting go at reset release keeps clear of the first bus cycle
   assign dataPin  = reset ? ~holdLow : 16'hFFFF;
   assign clockPin = reset ? ~clockLow : 1'h1;
endmodule // mode_select_driver

// *** tb/tb_top.sv ***
// bench for the reset pin state control block
`timescale 1ns/1ps
module tb_top;
   logic        clk = 0, reset = 1, csClockLow = 0;
   logic [15:0] hold = 16'h0000, dataPin;
   logic        clockPin, bootSelectFn = 1, strobeOutFn = 1, portDirWe = 0, portAltWe = 0;
   logic [10:0] chipSelectFn = 11'h7FF, chipSelectN, csAsAddress;
   logic [7:0]  portDirWr = 8'h00, portAltWr = 8'h00, portOe, portAlt;
   logic        bootChipSelectN, busPinOe, strobeOut, strobeOe, bootWide, portEMode;
   logic        portFMode, clockSourceSelect, modeValid, exceptionStart;
   int          n_mismatch = 0, n_checks = 0, k;
   // hold pattern with clock-low flag, then expected mode vector
   logic [32:0] rows [6] = '{{17'h00000, 16'h9001}, {17'h1FFFF, 16'h6FFF},
      {17'h00020, 16'h9381}, {17'h10101, 16'h4001}, {17'h00206, 16'hB07F},
      {17'h00088, 16'h9F81}};
   always #2.5 clk = ~clk;
   mode_select_driver part (.reset(reset), .holdLow(hold), .clockLow(csClockLow),
      .dataPin(dataPin), .clockPin(clockPin));
   reset_pin_state_control dut (.clk(clk), .reset(reset), .dataPinIn(dataPin),
      .clockSourceSelectPin(clockPin), .chipSelectFn(chipSelectFn),
      .bootSelectFn(bootSelectFn), .strobeOutFn(strobeOutFn), .portDirWr(portDirWr),
      .portDirWe(portDirWe), .portAltWr(portAltWr), .portAltWe(portAltWe),
      .chipSelectN(chipSelectN), .bootChipSelectN(bootChipSelectN), .busPinOe(busPinOe),
      .strobeOut(strobeOut), .strobeOe(strobeOe), .bootWide(bootWide),
      .csAsAddress(csAsAddress), .portEMode(portEMode), .portFMode(portFMode),
      .clockSourceSelect(clockSourceSelect), .modeValid(modeValid),
      .exceptionStart(exceptionStart), .portOe(portOe), .portAlt(portAlt));
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic [15:0] modeVec();
      return {bootWide, portEMode, portFMode, clockSourceSelect, csAsAddress, exceptionStart};
   endfunction
   initial begin
      for (int r = 0; r < 6; r++) begin
         {csClockLow, hold} = rows[r][32:16];
         reset = 1;
         // outputs are not looked at until reset has been held a while
         cyc(6);
         chk({5'h00, chipSelectN}, 16'h07FF);
         chk({bootChipSelectN, busPinOe, strobeOe, exceptionStart, modeValid}, 16'h0010);
         chk({portOe, portAlt}, 16'h0000);
         reset = 0;
         // writes this early must be dropped
         portDirWr = 8'hFF;
         portDirWe = 1;
         portAltWr = 8'hFF;
         portAltWe = 1;
         cyc(1);
         portDirWe = 0;
         portAltWe = 0;
         cyc(1);
         chk(modeVec(), rows[r][15:0]);
         cyc(1);
         chk({exceptionStart, modeValid}, 16'h0001);
         for (k = 0; k < 20 && busPinOe !== 1'b1; k++) cyc(1);
         if (busPinOe !== 1'b1) begin
            $display("unexpected at %0t: got %h expected %h", $time, busPinOe, 1'b1);
            n_mismatch++;
            end_sim();
         end
         chk({portOe, portAlt}, 16'h0000);
         // back-to-back direction writes, the later one wins
         portDirWr = 8'hA5;
         portDirWe = 1;
         portAltWr = 8'h3C;
         portAltWe = 1;
         cyc(1);
         portDirWr = 8'h5A;
         portAltWe = 0;
         cyc(1);
         portDirWe = 0;
         cyc(2);
         chk({portOe, portAlt}, 16'h5A3C);
         chk({5'h00, chipSelectN}, {5'h00, rows[r][11:1]});
         chk({15'h0000, bootChipSelectN}, 16'h0000);
         chk(modeVec(), rows[r][15:0] & 16'hFFFE);
         chk({14'h0000, strobeOe, busPinOe}, {14'h0000, !rows[r][14], 1'b1});
         $display("test row %0d done", r);
      end
      // no functional requests after release: selects idle, strobe follows
      bootSelectFn = 0;
      chipSelectFn = 11'h000;
      strobeOutFn = 0;
      cyc(3);
      chk({4'h0, bootChipSelectN, chipSelectN}, 16'h0FFF);
      chk({14'h0000, strobeOut, strobeOe}, 16'h0001);
      $display("test idle selects done");
      // reset in mid-run with requests active: inactive levels must win
      reset = 1;
      bootSelectFn = 1;
      chipSelectFn = 11'h7FF;
      cyc(2);
      chk({4'h0, bootChipSelectN, chipSelectN}, 16'h0FFF);
      chk({13'h0000, strobeOut, strobeOe, busPinOe}, 16'h0004);
      chk({portOe, portAlt}, 16'h0000);
      $display("test mid-run reset done");
      end_sim();
   end
endmodule // tb_top
